// ---- common/pirq_map.svh ----
// register map, field positions, reset values and bus codes of the priority select block
`ifndef PIRQ_MAP_SVH
`define PIRQ_MAP_SVH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define PIRQ_OFS_PRIO1        8'h00
`define PIRQ_OFS_CTRL         8'h04
`define PIRQ_OFS_EFFECT       8'h08
// ************************************************************
// field positions
// ************************************************************
`define PIRQ_BIT_TIMER_A      0
`define PIRQ_BIT_TIMER_B      1
`define PIRQ_BIT_SYNC_SERIAL  3
`define PIRQ_BIT_SERIAL_TX    4
`define PIRQ_BIT_SERIAL_RX    5
`define PIRQ_BIT_ADC          6
`define PIRQ_BIT_GLOBAL_EN    0
// ************************************************************
// masks, reset values and bus response codes
// ************************************************************
`define PIRQ_IMPL_MASK        8'h7B
`define PIRQ_PRIO1_RESET      8'h7B
`define PIRQ_CTRL_RESET       1'h0
`define PIRQ_RESP_OKAY        2'h0
`define PIRQ_RESP_SLVERR      2'h2
`endif

// ---- common/pirq_pkg.sv ----
// types shared by the priority select block
package pirq_pkg;
    typedef logic [7:0]  pirq_byte_t;
    typedef logic [31:0] pirq_word_t;
    typedef logic [1:0]  pirq_resp_t;
endpackage

// ---- common/pirq_reg_if.sv ----
// write port from the bus slave into the priority storage
`timescale 1ns/1ps
interface pirq_reg_if;
    import pirq_pkg::*;
    logic       wr_en;
    pirq_byte_t wr_data;
    pirq_byte_t value;
    modport master (output wr_en, output wr_data, input value);
    modport store  (input wr_en, input wr_data, output value);
endinterface

// ---- rtl/pirq_prio_store.sv ----
// storage of the six implemented priority bits
`timescale 1ns/1ps
`include "pirq_map.svh"
module pirq_prio_store (
    input  wire logic   clk,
    input  wire logic   rst,
    pirq_reg_if.store   port
);
    import pirq_pkg::*;
    typedef struct packed {
        pirq_byte_t prio;
    } pirq_store_t;
    pirq_store_t st_reg;
    pirq_store_t st_next;
    always_comb begin
        st_next = st_reg;
        if (port.wr_en) begin
            st_next.prio = port.wr_data & `PIRQ_IMPL_MASK;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg.prio <= `PIRQ_PRIO1_RESET;
        end else begin
            st_reg <= st_next;
        end
    end
    assign port.value = st_reg.prio;
    // ************************************************************
    // checks
    // ************************************************************
    property p_unimpl_zero;
        @(posedge clk) disable iff (rst) (st_reg.prio[7] == 1'b0) && (st_reg.prio[2] == 1'b0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");
    property p_reset_preset;
        @(posedge clk) rst |=> st_reg.prio == `PIRQ_PRIO1_RESET;
    endproperty
    a_reset_preset: assert property (p_reset_preset) else $error("preset wrong");
endmodule // pirq_prio_store

// ---- rtl/pirq_top.sv ----
// priority select register with AXI4-Lite slave and effective priority outputs
// Behaviour
// - bit 6 sets ADC interrupt priority
// - bit 5 sets serial receive priority
// - bit 4 sets serial transmit priority
// - bit 3 sets sync serial priority
// - bit 1 sets timer B match priority
// - bit 0 sets timer A overflow priority
// - bits 7 and 2 read zero, ignore writes
// - priorities act only with global enable set
`timescale 1ns/1ps
`include "pirq_map.svh"
module pirq_top (
    input  wire logic               CORE_CLK,
    input  wire logic               SYS_RST,
    input  wire logic [7:0]         S_AXI_AWADDR,
    input  wire logic               S_AXI_AWVALID,
    output logic                    S_AXI_AWREADY,
    input  wire pirq_pkg::pirq_word_t S_AXI_WDATA,
    input  wire logic [3:0]         S_AXI_WSTRB,
    input  wire logic               S_AXI_WVALID,
    output logic                    S_AXI_WREADY,
    output pirq_pkg::pirq_resp_t    S_AXI_BRESP,
    output logic                    S_AXI_BVALID,
    input  wire logic               S_AXI_BREADY,
    input  wire logic [7:0]         S_AXI_ARADDR,
    input  wire logic               S_AXI_ARVALID,
    output logic                    S_AXI_ARREADY,
    output pirq_pkg::pirq_word_t    S_AXI_RDATA,
    output pirq_pkg::pirq_resp_t    S_AXI_RRESP,
    output logic                    S_AXI_RVALID,
    input  wire logic               S_AXI_RREADY,
    output logic                    ADC_IRQ_HIGH_PRIO,
    output logic                    SERIAL_RX_IRQ_HIGH_PRIO,
    output logic                    SERIAL_TX_IRQ_HIGH_PRIO,
    output logic                    SYNC_SERIAL_IRQ_HIGH_PRIO,
    output logic                    TIMER_B_MATCH_IRQ_HIGH_PRIO,
    output logic                    TIMER_A_OVERFLOW_IRQ_HIGH_PRIO,
    output logic                    GLOBAL_PRIORITY_ENABLE
);
    import pirq_pkg::*;
    typedef struct packed {
        logic       aw_held;
        logic [7:0] aw_addr;
        logic       w_held;
        pirq_word_t w_data;
        logic [3:0] w_strb;
        logic       bvalid;
        pirq_resp_t bresp;
        logic       rvalid;
        pirq_word_t rdata;
        pirq_resp_t rresp;
        logic       global_priority_enable;
        pirq_byte_t effective;
    } pirq_state_t;
    pirq_state_t s_reg;
    pirq_state_t s_next;
    pirq_reg_if  prio_if ();
    pirq_prio_store u_store (
        .clk  (CORE_CLK),
        .rst  (SYS_RST),
        .port (prio_if.store)
    );
    logic       do_write;
    logic       do_read;
    pirq_byte_t prio_now;
    assign prio_now = prio_if.value;
    assign do_write = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
    assign do_read  = S_AXI_ARVALID && !s_reg.rvalid;
    // ************************************************************
    // write decode into priority storage
    // ************************************************************
    always_comb begin
        prio_if.wr_en   = do_write && (s_reg.aw_addr == `PIRQ_OFS_PRIO1) && s_reg.w_strb[0];
        prio_if.wr_data = s_reg.w_data[7:0];
    end
    // ************************************************************
    // bus slave and effective priorities
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        if (S_AXI_AWVALID && !s_reg.aw_held) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !s_reg.w_held) begin
            s_next.w_held = 1'b1;
            s_next.w_data = S_AXI_WDATA;
            s_next.w_strb = S_AXI_WSTRB;
        end
        if (do_write) begin
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = `PIRQ_RESP_OKAY;
            unique case (s_reg.aw_addr)
                `PIRQ_OFS_PRIO1: begin
                end
                `PIRQ_OFS_CTRL: begin
                    if (s_reg.w_strb[0]) begin
                        s_next.global_priority_enable = s_reg.w_data[`PIRQ_BIT_GLOBAL_EN];
                    end
                end
                `PIRQ_OFS_EFFECT: begin
                end
                default: s_next.bresp = `PIRQ_RESP_SLVERR;
            endcase
        end
        if (s_reg.bvalid && S_AXI_BREADY) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.rvalid && S_AXI_RREADY) begin
            s_next.rvalid = 1'b0;
        end
        if (do_read) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = `PIRQ_RESP_OKAY;
            s_next.rdata  = 32'h00000000;
            unique case (S_AXI_ARADDR)
                `PIRQ_OFS_PRIO1:  s_next.rdata[7:0] = prio_now & `PIRQ_IMPL_MASK;
                `PIRQ_OFS_CTRL:   s_next.rdata[0]   = s_reg.global_priority_enable;
                `PIRQ_OFS_EFFECT: s_next.rdata[7:0] = s_reg.effective;
                default:          s_next.rresp      = `PIRQ_RESP_SLVERR;
            endcase
        end
        // clear enable leaves every source in the default class
        s_next.effective = s_reg.global_priority_enable ? (prio_now & `PIRQ_IMPL_MASK)
                                                        : 8'h00;
    end
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            s_reg <= '0;
            s_reg.global_priority_enable <= `PIRQ_CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end
    // ************************************************************
    // outputs
    // ************************************************************
    assign S_AXI_AWREADY = !s_reg.aw_held;
    assign S_AXI_WREADY  = !s_reg.w_held;
    assign S_AXI_BVALID  = s_reg.bvalid;
    assign S_AXI_BRESP   = s_reg.bresp;
    assign S_AXI_ARREADY = !s_reg.rvalid;
    assign S_AXI_RVALID  = s_reg.rvalid;
    assign S_AXI_RDATA   = s_reg.rdata;
    assign S_AXI_RRESP   = s_reg.rresp;
    assign ADC_IRQ_HIGH_PRIO              = s_reg.effective[`PIRQ_BIT_ADC];
    assign SERIAL_RX_IRQ_HIGH_PRIO        = s_reg.effective[`PIRQ_BIT_SERIAL_RX];
    assign SERIAL_TX_IRQ_HIGH_PRIO        = s_reg.effective[`PIRQ_BIT_SERIAL_TX];
    assign SYNC_SERIAL_IRQ_HIGH_PRIO      = s_reg.effective[`PIRQ_BIT_SYNC_SERIAL];
    assign TIMER_B_MATCH_IRQ_HIGH_PRIO    = s_reg.effective[`PIRQ_BIT_TIMER_B];
    assign TIMER_A_OVERFLOW_IRQ_HIGH_PRIO = s_reg.effective[`PIRQ_BIT_TIMER_A];
    assign GLOBAL_PRIORITY_ENABLE         = s_reg.global_priority_enable;
    // ************************************************************
    // checks
    // ************************************************************
    property p_adc;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            !SYS_RST |=> ADC_IRQ_HIGH_PRIO ==
                ($past(prio_now[6]) && $past(s_reg.global_priority_enable));
    endproperty
    a_adc: assert property (p_adc) else $error("adc priority mismatch");
    property p_rx;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            !SYS_RST |=> SERIAL_RX_IRQ_HIGH_PRIO ==
                ($past(prio_now[5]) && $past(GLOBAL_PRIORITY_ENABLE));
    endproperty
    a_rx: assert property (p_rx) else $error("rx priority mismatch");
    property p_tx;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            !SYS_RST |=> SERIAL_TX_IRQ_HIGH_PRIO ==
                ($past(prio_now[4]) && $past(GLOBAL_PRIORITY_ENABLE));
    endproperty
    a_tx: assert property (p_tx) else $error("tx priority mismatch");
    property p_sync;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            !SYS_RST |=> SYNC_SERIAL_IRQ_HIGH_PRIO ==
                ($past(prio_now[3]) && $past(GLOBAL_PRIORITY_ENABLE));
    endproperty
    a_sync: assert property (p_sync) else $error("sync serial priority mismatch");
    property p_tmrb;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            !SYS_RST |=> TIMER_B_MATCH_IRQ_HIGH_PRIO ==
                ($past(prio_now[1]) && $past(GLOBAL_PRIORITY_ENABLE));
    endproperty
    a_tmrb: assert property (p_tmrb) else $error("timer b priority mismatch");
    property p_tmra;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            !SYS_RST |=> TIMER_A_OVERFLOW_IRQ_HIGH_PRIO ==
                ($past(prio_now[0]) && $past(GLOBAL_PRIORITY_ENABLE));
    endproperty
    a_tmra: assert property (p_tmra) else $error("timer a priority mismatch");
    property p_read_zero;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            do_read && S_AXI_ARADDR == `PIRQ_OFS_PRIO1
                |=> S_AXI_RDATA[7] == 1'b0 && S_AXI_RDATA[2] == 1'b0;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("unimplemented bit nonzero");
    property p_disabled;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            !GLOBAL_PRIORITY_ENABLE [*2] |-> s_reg.effective == 8'h00;
    endproperty
    a_disabled: assert property (p_disabled) else $error("priority active when off");
    property p_ctrl_write;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            do_write && s_reg.aw_addr == `PIRQ_OFS_CTRL && s_reg.w_strb[0]
                |=> GLOBAL_PRIORITY_ENABLE == $past(s_reg.w_data[`PIRQ_BIT_GLOBAL_EN]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("enable write lost");
    property p_strobe_off;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            do_write && !s_reg.w_strb[0] |=> $stable(prio_now);
    endproperty
    a_strobe_off: assert property (p_strobe_off) else $error("written without strobe");
    property p_write_lands;
        @(posedge CORE_CLK) disable iff (SYS_RST)
            prio_if.wr_en |=> prio_now == ($past(s_reg.w_data[7:0]) & `PIRQ_IMPL_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("priority write lost");
    c_write: cover property (@(posedge CORE_CLK) prio_if.wr_en);
    c_read:  cover property (@(posedge CORE_CLK) do_read && S_AXI_ARADDR == `PIRQ_OFS_PRIO1);
    c_en:    cover property (@(posedge CORE_CLK) $rose(GLOBAL_PRIORITY_ENABLE));
    c_err:   cover property (@(posedge CORE_CLK) S_AXI_BVALID && S_AXI_BRESP == `PIRQ_RESP_SLVERR);
    c_rerr:  cover property (@(posedge CORE_CLK) S_AXI_RVALID && S_AXI_RRESP == `PIRQ_RESP_SLVERR);
endmodule // pirq_top

// ---- test/pirq_top_test.sv ----
// self-checking bench for the priority select register block
`timescale 1ns/1ps
`include "pirq_map.svh"
module pirq_top_test;
    import pirq_pkg::*;
    `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
        $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
    logic       clk     = 1'b0;
    logic       rst     = 1'b1;
    logic [7:0] awaddr  = 8'h00;
    logic [7:0] araddr  = 8'h00;
    logic       awvalid = 1'b0;
    logic       wvalid  = 1'b0;
    logic       bready  = 1'b0;
    logic       arvalid = 1'b0;
    logic       rready  = 1'b0;
    pirq_word_t wdata   = 32'h0;
    logic [3:0] wstrb   = 4'h0;
    logic       awready, wready, bvalid, arready, rvalid;
    pirq_resp_t bresp, rresp;
    pirq_word_t rdata;
    logic       adc, rx, tx, ssp, tmb, tma, gen;
    pirq_byte_t eff;
    int         n_fail          = 0;
    int         samples_checked = 0;
    int         i;
    assign eff = {1'b0, adc, rx, tx, ssp, 1'b0, tmb, tma};
    always #2 clk = ~clk;
    pirq_top dut (
        .CORE_CLK(clk), .SYS_RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .ADC_IRQ_HIGH_PRIO(adc), .SERIAL_RX_IRQ_HIGH_PRIO(rx),
        .SERIAL_TX_IRQ_HIGH_PRIO(tx), .SYNC_SERIAL_IRQ_HIGH_PRIO(ssp),
        .TIMER_B_MATCH_IRQ_HIGH_PRIO(tmb), .TIMER_A_OVERFLOW_IRQ_HIGH_PRIO(tma),
        .GLOBAL_PRIORITY_ENABLE(gen)
    );
    // ************************************************************
    // final report and bus tasks
    // ************************************************************
    task automatic final_report();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input pirq_word_t d, input logic [3:0] s,
                      input pirq_resp_t er);
        int k;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                `CHK(bresp, er)
                return;
            end
        end
        $display("mismatch at %0t: write timed out", $time);
        n_fail++;
        final_report();
    endtask
    task automatic rd(input logic [7:0] a, input pirq_word_t ed, input pirq_resp_t er);
        int k;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                `CHK(rresp, er)
                if (er === `PIRQ_RESP_OKAY) `CHK(rdata, ed)
                return;
            end
        end
        $display("mismatch at %0t: read timed out", $time);
        n_fail++;
        final_report();
    endtask
    // waits for the extra output register, then compares the priority outputs
    task automatic chk_eff(input pirq_byte_t e);
        repeat (3) @(posedge clk);
        #1;
        `CHK(eff, e)
    endtask
    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`PIRQ_OFS_PRIO1, 32'h7B, `PIRQ_RESP_OKAY);
        rd(`PIRQ_OFS_CTRL, 32'h0, `PIRQ_RESP_OKAY);
        chk_eff(8'h00);
        wr(`PIRQ_OFS_CTRL, 32'h1, 4'h1, `PIRQ_RESP_OKAY);
        chk_eff(8'h7B);
        `CHK(gen, 1'b1)
        for (i = 0; i < 8; i++) begin
            wr(`PIRQ_OFS_PRIO1, 32'h1 << i, 4'h1, `PIRQ_RESP_OKAY);
            rd(`PIRQ_OFS_PRIO1, (32'h1 << i) & 32'h7B, `PIRQ_RESP_OKAY);
            chk_eff((8'h01 << i) & 8'h7B);
        end
        wr(`PIRQ_OFS_PRIO1, 32'hFFFFFFFF, 4'hF, `PIRQ_RESP_OKAY);
        rd(`PIRQ_OFS_PRIO1, 32'h7B, `PIRQ_RESP_OKAY);
        wr(`PIRQ_OFS_PRIO1, 32'h0, 4'h0, `PIRQ_RESP_OKAY);
        rd(`PIRQ_OFS_PRIO1, 32'h7B, `PIRQ_RESP_OKAY);
        wr(`PIRQ_OFS_PRIO1, 32'h2A, 4'h1, `PIRQ_RESP_OKAY);
        rd(`PIRQ_OFS_EFFECT, 32'h2A, `PIRQ_RESP_OKAY);
        wr(`PIRQ_OFS_EFFECT, 32'h0, 4'h1, `PIRQ_RESP_OKAY);
        rd(`PIRQ_OFS_PRIO1, 32'h2A, `PIRQ_RESP_OKAY);
        wr(`PIRQ_OFS_CTRL, 32'h0, 4'h1, `PIRQ_RESP_OKAY);
        chk_eff(8'h00);
        rd(`PIRQ_OFS_EFFECT, 32'h0, `PIRQ_RESP_OKAY);
        rd(`PIRQ_OFS_PRIO1, 32'h2A, `PIRQ_RESP_OKAY);
        wr(8'h10, 32'h0, 4'h1, `PIRQ_RESP_SLVERR);
        rd(8'h10, 32'h0, `PIRQ_RESP_SLVERR);
        rd(`PIRQ_OFS_PRIO1, 32'h2A, `PIRQ_RESP_OKAY);
        wr(`PIRQ_OFS_CTRL, 32'h1, 4'h1, `PIRQ_RESP_OKAY);
        chk_eff(8'h2A);
        // second reset in mid-run brings the preset back
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(`PIRQ_OFS_PRIO1, 32'h7B, `PIRQ_RESP_OKAY);
        rd(`PIRQ_OFS_CTRL, 32'h0, `PIRQ_RESP_OKAY);
        chk_eff(8'h00);
        `CHK(gen, 1'b0)
        final_report();
    end
endmodule // pirq_top_test
